/* File: include/bsg_pkg.sv */
// constants and types for the bus-shared gpio ports h and j
// Summary of operation
// - Port h has eight two-way pins, and a direction bit of 1 turns that pin's driver off.
// - A port h direction bit of 0 drives the pin from the same bit of the output latch.
// - Read-modify-write on the port h latch register works on the stored latch, not on pins.
// - After reset the upper four port h pins are analog inputs.
// - After reset the lower four port h pins carry address bits 19 to 16.
// - The analog pin config register picks digital or analog for the upper port h pins.
// - The memory interface config picks gpio or address bus for the lower port h pins.
// - While the upper port h pins are analog, digital reads of them return 0.
// - Port j has eight two-way pins; direction 1 is high impedance, 0 drives the latch.
// - Read-modify-write on the port j latch register works on the stored latch.
// - In 8-bit external mode the port j pins carry data bus bits 7 to 0.
// - The memory interface config picks gpio or data bus for the port j pins.
// - After power-on reset every port j pin belongs to the system bus in 8-bit mode.
// - Shared pins become gpio only with external bus disable set and internal execution, except port j, which is also gpio in 16-bit mode.
package bsg_pkg;
  localparam int          DW              = 8;
  localparam int          AW              = 4;
  localparam logic [3:0]  ADDR_H_DIR      = 4'h0;
  localparam logic [3:0]  ADDR_H_PINS     = 4'h1;
  localparam logic [3:0]  ADDR_H_LAT      = 4'h2;
  localparam logic [3:0]  ADDR_J_DIR      = 4'h3;
  localparam logic [3:0]  ADDR_J_PINS     = 4'h4;
  localparam logic [3:0]  ADDR_J_LAT      = 4'h5;
  localparam logic [3:0]  ADDR_ANALOG     = 4'h6;
  localparam logic [3:0]  ADDR_MEMCFG     = 4'h7;
  localparam logic [7:0]  DIR_RST         = 8'hFF;
  localparam logic [7:0]  LAT_RST         = 8'h00;
  localparam logic [7:0]  ANALOG_RST      = 8'h00;
  localparam logic [7:0]  MEMCFG_RST      = 8'h00;
  localparam logic [7:0]  ANALOG_MASK     = 8'h3F;
  localparam logic [7:0]  MEMCFG_MASK     = 8'hF3;
  localparam int          XBUS_OFF        = 7;
  localparam logic [3:0]  ANALOG_DIGITAL  = 4'hF;
  localparam logic [7:0]  H_ADDR_PINS     = 8'h0F;
  localparam logic [7:0]  H_ANALOG_PINS   = 8'hF0;
  localparam logic [7:0]  ALL_PINS        = 8'hFF;
  localparam logic [7:0]  NO_PINS         = 8'h00;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bsg_req_t;
endpackage

/* File: rtl/bsg_pin_bank.sv */
// one 8-bit shared pin bank: input synchroniser and registered pin drive
`timescale 1ns/1ps
module bsg_pin_bank (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  pins_in,
  input  wire logic [7:0]  dir_in,
  input  wire logic [7:0]  lat_in,
  input  wire logic [7:0]  bus_own_in,
  input  wire logic [7:0]  bus_val_in,
  input  wire logic [7:0]  bus_drive_n_in,
  input  wire logic [7:0]  analog_in,
  output logic      [7:0]  pins_out,
  output logic      [7:0]  drive_n_out,
  output logic      [7:0]  sync_out
);
  logic [7:0] meta_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_reg <= pins_in;
      sync_out <= meta_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      wire drive_n_next;
      wire val_next;
      // bus owner wins; analog pins never drive, so the adc sees the raw level
      assign drive_n_next = bus_own_in[i] ? bus_drive_n_in[i] :
                            (analog_in[i] ? 1'b1 : dir_in[i]);
      assign val_next     = bus_own_in[i] ? bus_val_in[i] : lat_in[i];
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pins_out[i]    <= 1'b0;
          drive_n_out[i] <= 1'b1;
        end else begin
          pins_out[i]    <= val_next;
          drive_n_out[i] <= drive_n_next;
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/bsg_ports.sv */
// bus-shared gpio ports h and j with register slave and pin ownership
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module bsg_ports (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire bsg_pkg::bsg_req_t bus_req_in,
  output logic [bsg_pkg::DW-1:0] rd_data_out,
  input  wire logic              internal_exec_in,
  input  wire logic              eight_bit_mode_in,
  input  wire logic [3:0]        upper_address_bits_in,
  input  wire logic [7:0]        system_data_bits_in,
  input  wire logic              system_data_drive_n_in,
  input  wire logic [7:0]        port_h_pins_in,
  output logic      [7:0]        port_h_pins_out,
  output logic      [7:0]        port_h_drive_n_out,
  input  wire logic [7:0]        port_j_pins_in,
  output logic      [7:0]        port_j_pins_out,
  output logic      [7:0]        port_j_drive_n_out,
  output logic      [7:0]        system_data_bits_out,
  output logic                   gpio_mode_out,
  output logic      [3:0]        port_h_analog_out
);
  import bsg_pkg::*;

  logic [7:0] port_h_direction_reg;
  logic [7:0] port_h_output_latch_reg;
  logic [7:0] port_j_direction_reg;
  logic [7:0] port_j_output_latch_reg;
  logic [7:0] analog_pin_config_reg;
  logic [7:0] memory_interface_config_reg;
  logic [7:0] rd_data_next;

  // register decode
  wire        wr_h_dir  = bus_req_in.wr && (bus_req_in.addr == ADDR_H_DIR);
  wire        wr_h_lat  = bus_req_in.wr && ((bus_req_in.addr == ADDR_H_LAT) ||
                                            (bus_req_in.addr == ADDR_H_PINS));
  wire        wr_j_dir  = bus_req_in.wr && (bus_req_in.addr == ADDR_J_DIR);
  wire        wr_j_lat  = bus_req_in.wr && ((bus_req_in.addr == ADDR_J_LAT) ||
                                            (bus_req_in.addr == ADDR_J_PINS));
  wire        wr_analog = bus_req_in.wr && (bus_req_in.addr == ADDR_ANALOG);
  wire        wr_memcfg = bus_req_in.wr && (bus_req_in.addr == ADDR_MEMCFG);

  // pin ownership
  // gpio needs both the disable bit and internal fetches; either alone keeps the bus
  wire        gpio_en = memory_interface_config_reg[XBUS_OFF] && internal_exec_in;
  wire [7:0]  h_bus_own = gpio_en ? NO_PINS : H_ADDR_PINS;
  // in 16-bit mode the data bus lives elsewhere, so port j is left as gpio
  wire        j_bus     = !gpio_en && eight_bit_mode_in;
  wire [7:0]  j_bus_own = j_bus ? ALL_PINS : NO_PINS;
  wire        h_digital = (analog_pin_config_reg[3:0] == ANALOG_DIGITAL);
  wire [7:0]  h_analog  = h_digital ? NO_PINS : H_ANALOG_PINS;
  wire [7:0]  h_bus_val = {4'h0, upper_address_bits_in};
  wire [7:0]  j_drive_n = {8{system_data_drive_n_in}};

  wire [7:0]  h_sync;
  wire [7:0]  j_sync;

  // read mux
  wire [7:0]  h_pins_rd = h_sync & ~h_analog;
  wire [7:0]  rd_sel =
      (bus_req_in.addr == ADDR_H_DIR)  ? port_h_direction_reg :
      (bus_req_in.addr == ADDR_H_PINS) ? h_pins_rd :
      (bus_req_in.addr == ADDR_H_LAT)  ? port_h_output_latch_reg :
      (bus_req_in.addr == ADDR_J_DIR)  ? port_j_direction_reg :
      (bus_req_in.addr == ADDR_J_PINS) ? j_sync :
      (bus_req_in.addr == ADDR_J_LAT)  ? port_j_output_latch_reg :
      (bus_req_in.addr == ADDR_ANALOG) ? analog_pin_config_reg :
      (bus_req_in.addr == ADDR_MEMCFG) ? memory_interface_config_reg :
      8'h00;

  // read data stand for the one cycle after the strobe, zero otherwise
  assign rd_data_next = bus_req_in.rd ? rd_sel : 8'h00;

  // registers
  // direction and latch keep their values while the bus owns the pins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_h_direction_reg <= DIR_RST;
      port_j_direction_reg <= DIR_RST;
    end else begin
      if (wr_h_dir) begin
        port_h_direction_reg <= bus_req_in.wdata;
      end
      if (wr_j_dir) begin
        port_j_direction_reg <= bus_req_in.wdata;
      end
    end
  end

  // pins-register writes land in the latch, so no pin level is copied back
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_h_output_latch_reg <= LAT_RST;
      port_j_output_latch_reg <= LAT_RST;
    end else begin
      if (wr_h_lat) begin
        port_h_output_latch_reg <= bus_req_in.wdata;
      end
      if (wr_j_lat) begin
        port_j_output_latch_reg <= bus_req_in.wdata;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      analog_pin_config_reg       <= ANALOG_RST;
      memory_interface_config_reg <= MEMCFG_RST;
    end else begin
      if (wr_analog) begin
        analog_pin_config_reg <= bus_req_in.wdata & ANALOG_MASK;
      end
      if (wr_memcfg) begin
        memory_interface_config_reg <= bus_req_in.wdata & MEMCFG_MASK;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out       <= 8'h00;
      gpio_mode_out     <= 1'b0;
      port_h_analog_out <= 4'hF;
    end else begin
      rd_data_out       <= rd_data_next;
      gpio_mode_out     <= gpio_en;
      port_h_analog_out <= h_analog[7:4];
    end
  end

  // pin banks
  bsg_pin_bank u_bank_h (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .pins_in        (port_h_pins_in),
    .dir_in         (port_h_direction_reg),
    .lat_in         (port_h_output_latch_reg),
    .bus_own_in     (h_bus_own),
    .bus_val_in     (h_bus_val),
    .bus_drive_n_in (NO_PINS),
    .analog_in      (h_analog),
    .pins_out       (port_h_pins_out),
    .drive_n_out    (port_h_drive_n_out),
    .sync_out       (h_sync)
  );

  bsg_pin_bank u_bank_j (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .pins_in        (port_j_pins_in),
    .dir_in         (port_j_direction_reg),
    .lat_in         (port_j_output_latch_reg),
    .bus_own_in     (j_bus_own),
    .bus_val_in     (system_data_bits_in),
    .bus_drive_n_in (j_drive_n),
    .analog_in      (NO_PINS),
    .pins_out       (port_j_pins_out),
    .drive_n_out    (port_j_drive_n_out),
    .sync_out       (j_sync)
  );

  // the bus logic samples data through the same two-stage synchroniser
  assign system_data_bits_out = j_sync;

  // checks
  property p_h_dir_drive;
    @(posedge clk_in) disable iff (!resetn_in)
      (gpio_en && h_digital) |=> (port_h_drive_n_out == $past(port_h_direction_reg));
  endproperty
  a_h_dir_drive: assert property (p_h_dir_drive)
    else $error("port h driver does not follow direction");

  property p_h_latch_drive;
    @(posedge clk_in) disable iff (!resetn_in)
      gpio_en |=> (port_h_pins_out == $past(port_h_output_latch_reg));
  endproperty
  a_h_latch_drive: assert property (p_h_latch_drive)
    else $error("port h pins do not carry the latch");

  property p_h_rmw;
    @(posedge clk_in) disable iff (!resetn_in)
      (bus_req_in.wr && bus_req_in.addr == ADDR_H_PINS) ##1
      (bus_req_in.rd && bus_req_in.addr == ADDR_H_LAT)
      |=> (rd_data_out == $past(bus_req_in.wdata, 2));
  endproperty
  a_h_rmw: assert property (p_h_rmw)
    else $error("port h latch read does not return the written value");

  property p_h_analog_off;
    @(posedge clk_in) disable iff (!resetn_in)
      (!h_digital) |=> (port_h_drive_n_out[7:4] == 4'hF && port_h_analog_out == 4'hF);
  endproperty
  a_h_analog_off: assert property (p_h_analog_off)
    else $error("analog port h pin is driven");

  property p_h_addr_bus;
    @(posedge clk_in) disable iff (!resetn_in)
      (!gpio_en) |=> (port_h_pins_out[3:0] == $past(upper_address_bits_in) &&
                      port_h_drive_n_out[3:0] == 4'h0);
  endproperty
  a_h_addr_bus: assert property (p_h_addr_bus)
    else $error("port h lower pins do not carry the address");

  property p_h_digital_sel;
    @(posedge clk_in) disable iff (!resetn_in)
      (wr_analog && bus_req_in.wdata[3:0] == ANALOG_DIGITAL) |=> ##1
      (port_h_analog_out == 4'h0);
  endproperty
  a_h_digital_sel: assert property (p_h_digital_sel)
    else $error("analog config did not select digital pins");

  property p_h_gpio_sel;
    @(posedge clk_in) disable iff (!resetn_in)
      (wr_memcfg && bus_req_in.wdata[XBUS_OFF] && internal_exec_in) ##1 internal_exec_in
      |=> gpio_mode_out;
  endproperty
  a_h_gpio_sel: assert property (p_h_gpio_sel)
    else $error("memory config did not release the shared pins");

  property p_h_analog_read;
    @(posedge clk_in) disable iff (!resetn_in)
      (bus_req_in.rd && bus_req_in.addr == ADDR_H_PINS && !h_digital)
      |=> (rd_data_out[7:4] == 4'h0);
  endproperty
  a_h_analog_read: assert property (p_h_analog_read)
    else $error("analog port h bits read as nonzero");

  property p_j_dir_drive;
    @(posedge clk_in) disable iff (!resetn_in)
      (!j_bus) |=> (port_j_drive_n_out == $past(port_j_direction_reg) &&
                    port_j_pins_out == $past(port_j_output_latch_reg));
  endproperty
  a_j_dir_drive: assert property (p_j_dir_drive)
    else $error("port j gpio drive is wrong");

  property p_j_rmw;
    @(posedge clk_in) disable iff (!resetn_in)
      (bus_req_in.rd && bus_req_in.addr == ADDR_J_LAT)
      |=> (rd_data_out == $past(port_j_output_latch_reg));
  endproperty
  a_j_rmw: assert property (p_j_rmw)
    else $error("port j latch read is not the stored latch");

  property p_j_data_bus;
    @(posedge clk_in) disable iff (!resetn_in)
      j_bus |=> (port_j_pins_out == $past(system_data_bits_in) &&
                 port_j_drive_n_out == {8{$past(system_data_drive_n_in)}});
  endproperty
  a_j_data_bus: assert property (p_j_data_bus)
    else $error("port j does not carry the data bus");

  property p_j_por_bus;
    @(posedge clk_in) disable iff (!resetn_in)
      (!memory_interface_config_reg[XBUS_OFF] && eight_bit_mode_in) |-> j_bus;
  endproperty
  a_j_por_bus: assert property (p_j_por_bus)
    else $error("port j left the bus without the disable bit");

  property p_gpio_needs_internal;
    @(posedge clk_in) disable iff (!resetn_in)
      (!internal_exec_in) |=> !gpio_mode_out;
  endproperty
  a_gpio_needs_internal: assert property (p_gpio_needs_internal)
    else $error("gpio mode while executing externally");

  property p_bus_keeps_regs;
    @(posedge clk_in) disable iff (!resetn_in)
      (j_bus && wr_j_dir) |=> (port_j_direction_reg == $past(bus_req_in.wdata));
  endproperty
  a_bus_keeps_regs: assert property (p_bus_keeps_regs)
    else $error("port j direction lost while bus owns the pins");

  property p_bus_dir_stable;
    @(posedge clk_in) disable iff (!resetn_in)
      (j_bus && !wr_j_dir) |=> $stable(port_j_direction_reg);
  endproperty
  a_bus_dir_stable: assert property (p_bus_dir_stable)
    else $error("port j direction changed without a write");

  property p_h_lat_keep;
    @(posedge clk_in) disable iff (!resetn_in)
      (!gpio_en && !wr_h_lat) |=> $stable(port_h_output_latch_reg);
  endproperty
  a_h_lat_keep: assert property (p_h_lat_keep)
    else $error("port h latch changed while the bus owns the pins");

  property p_j_lat_keep;
    @(posedge clk_in) disable iff (!resetn_in)
      (j_bus && !wr_j_lat) |=> $stable(port_j_output_latch_reg);
  endproperty
  a_j_lat_keep: assert property (p_j_lat_keep)
    else $error("port j latch changed while the bus owns the pins");

  property p_h_dir_write;
    @(posedge clk_in) disable iff (!resetn_in)
      wr_h_dir |=> (port_h_direction_reg == $past(bus_req_in.wdata));
  endproperty
  a_h_dir_write: assert property (p_h_dir_write)
    else $error("port h direction write lost");

  property p_h_lat_write;
    @(posedge clk_in) disable iff (!resetn_in)
      wr_h_lat |=> (port_h_output_latch_reg == $past(bus_req_in.wdata));
  endproperty
  a_h_lat_write: assert property (p_h_lat_write)
    else $error("port h latch write lost");

  property p_j_lat_write;
    @(posedge clk_in) disable iff (!resetn_in)
      wr_j_lat |=> (port_j_output_latch_reg == $past(bus_req_in.wdata));
  endproperty
  a_j_lat_write: assert property (p_j_lat_write)
    else $error("port j latch write lost");

  property p_h_upper_dir;
    @(posedge clk_in) disable iff (!resetn_in)
      h_digital |=> (port_h_drive_n_out[7:4] == $past(port_h_direction_reg[7:4]));
  endproperty
  a_h_upper_dir: assert property (p_h_upper_dir)
    else $error("digital upper port h pins ignore direction");

  property p_j_gpio_wide;
    @(posedge clk_in) disable iff (!resetn_in)
      (!eight_bit_mode_in) |=> (port_j_drive_n_out == $past(port_j_direction_reg));
  endproperty
  a_j_gpio_wide: assert property (p_j_gpio_wide)
    else $error("port j taken by the bus outside 8-bit mode");

  property p_gpio_on;
    @(posedge clk_in) disable iff (!resetn_in)
      (memory_interface_config_reg[XBUS_OFF] && internal_exec_in) |=> gpio_mode_out;
  endproperty
  a_gpio_on: assert property (p_gpio_on)
    else $error("gpio mode missing with bus disabled and internal execution");

  property p_rd_idle;
    @(posedge clk_in) disable iff (!resetn_in)
      (!bus_req_in.rd) |=> (rd_data_out == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");

  property p_cfg_reserved;
    @(posedge clk_in) disable iff (!resetn_in)
      (wr_analog || wr_memcfg) |=> (analog_pin_config_reg[7:6] == 2'h0 &&
                                    memory_interface_config_reg[3:2] == 2'h0);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("reserved config bits stored");

endmodule

/* File: tb/bsg_ext_model.sv */
// far-side model: external memory and analog circuitry on both shared ports
`timescale 1ns/1ps
module bsg_ext_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] dev_val_in,
  input  wire logic [15:0] dev_drive_n_in,
  input  wire logic [15:0] ext_val_in,
  input  wire logic [15:0] ext_en_in,
  output logic      [15:0] level_out
);
  logic [15:0] last_reg;
  // undriven lines without ext_en flip every cycle so a stale level never reads as good
  assign level_out = (dev_val_in & ~dev_drive_n_in)
                   | (dev_drive_n_in & ext_en_in & ext_val_in)
                   | (dev_drive_n_in & ~ext_en_in & ~last_reg);
  always_ff @(posedge clk_in) begin
    last_reg <= level_out;
  end
endmodule

/* File: tb/bus_shared_gpio_ports_h_j_tb.sv */
// self-checking bench for ports h and j against an integer register model
`timescale 1ns/1ps
module bus_shared_gpio_ports_h_j_tb;
  import bsg_pkg::*;
  logic       clk_in, resetn_in, internal_exec, eight_bit, sys_dn, gpio_mode;
  bsg_req_t   req;
  logic [7:0] rd_data, h_out, h_dn, h_lvl, j_out, j_dn, j_lvl, sys_data, sys_out;
  logic [7:0] ext_h, ext_j, ext_en;
  logic [3:0] addr_hi, h_analog;
  int         m [8];
  integer     seed;
  int         fails, check_count, cyc;

  bsg_ports bsg_ports_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus_req_in(req), .rd_data_out(rd_data),
    .internal_exec_in(internal_exec), .eight_bit_mode_in(eight_bit),
    .upper_address_bits_in(addr_hi), .system_data_bits_in(sys_data),
    .system_data_drive_n_in(sys_dn), .port_h_pins_in(h_lvl), .port_h_pins_out(h_out),
    .port_h_drive_n_out(h_dn), .port_j_pins_in(j_lvl), .port_j_pins_out(j_out),
    .port_j_drive_n_out(j_dn), .system_data_bits_out(sys_out),
    .gpio_mode_out(gpio_mode), .port_h_analog_out(h_analog));

  bsg_ext_model bsg_ext_model_i (
    .clk_in(clk_in), .dev_val_in({j_out, h_out}), .dev_drive_n_in({j_dn, h_dn}),
    .ext_val_in({ext_j, ext_h}), .ext_en_in({ext_en, ext_en}), .level_out({j_lvl, h_lvl}));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic bit gpio_e();
    return m[7][7] && internal_exec;
  endfunction
  function automatic bit dig_e();
    return m[6][3:0] == 4'hF;
  endfunction
  function automatic logic [7:0] h_dn_e();
    return {dig_e() ? m[0][7:4] : 4'hF, gpio_e() ? m[0][3:0] : 4'h0};
  endfunction
  function automatic logic [7:0] h_val_e();
    return {m[2][7:4], gpio_e() ? m[2][3:0] : addr_hi};
  endfunction
  function automatic bit j_bus();
    return !gpio_e() && eight_bit;
  endfunction
  function automatic logic [7:0] j_dn_e();
    return j_bus() ? {8{sys_dn}} : m[3][7:0];
  endfunction
  function automatic logic [7:0] j_val_e();
    return j_bus() ? sys_data : m[5][7:0];
  endfunction
  function automatic logic [7:0] lvl(logic [7:0] v, logic [7:0] dn, logic [7:0] e);
    return (v & ~dn) | (e & dn);
  endfunction
  function automatic logic [7:0] rd_e(int a);
    case (a)
      1: return lvl(h_val_e(), h_dn_e(), ext_h) & (dig_e() ? 8'hFF : 8'h0F);
      4: return lvl(j_val_e(), j_dn_e(), ext_j);
      6: return m[6][7:0] & 8'h3F;
      7: return m[7][7:0] & 8'hF3;
      default: return (a < 8) ? m[a][7:0] : 8'h00;
    endcase
  endfunction

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(int a, int d);
    @(posedge clk_in);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a[3:0], wdata: d[7:0]};
    @(posedge clk_in);
    req <= '0;
    if (a == 1) m[2] = d & 255;
    else if (a == 4) m[5] = d & 255;
    else if (a < 8) m[a] = d & 255;
  endtask

  task automatic rd(int a);
    @(posedge clk_in);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a[3:0], wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 chk("read data", rd_e(a), rd_data);
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wr_rd(int a, int d, int b);
    @(posedge clk_in);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a[3:0], wdata: d[7:0]};
    @(posedge clk_in);
    req <= '{rd: 1'b1, wr: 1'b0, addr: b[3:0], wdata: 8'h00};
    if (a == 1) m[2] = d & 255;
    else if (a == 4) m[5] = d & 255;
    else if (a < 8) m[a] = d & 255;
    @(posedge clk_in);
    req <= '0;
    #1 chk("read data", rd_e(b), rd_data);
  endtask

  // pin inputs need two sync stages, so four edges cover every path
  task automatic chk_pins();
    repeat (4) @(posedge clk_in);
    #1;
    chk("h drive_n", h_dn_e(), h_dn);
    chk("h pins", h_val_e() & ~h_dn_e(), h_out & ~h_dn_e());
    chk("j drive_n", j_dn_e(), j_dn);
    chk("j pins", j_val_e() & ~j_dn_e(), j_out & ~j_dn_e());
    chk("h analog", {4'h0, dig_e() ? 4'h0 : 4'hF}, {4'h0, h_analog});
    chk("gpio mode", {7'h0, gpio_e()}, {7'h0, gpio_mode});
    chk("sys data", lvl(j_val_e(), j_dn_e(), ext_j), sys_out);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    seed = 22769;
    fails = 0;
    check_count = 0;
    cyc = 0;
    req = '0;
    internal_exec = 1'b0;
    eight_bit = 1'b1;
    sys_dn = 1'b0;
    addr_hi = 4'hA;
    sys_data = 8'h3C;
    ext_h = 8'h96;
    ext_j = 8'h69;
    ext_en = 8'hFF;
    foreach (m[i]) m[i] = (i == 0 || i == 3) ? 255 : 0;
    resetn_in = 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    chk_pins();
    for (int a = 0; a < 16; a++) rd(a);
    wr(0, 8'h00);
    wr(2, 8'h5A);
    wr(3, 8'h00);
    wr_rd(4, 8'hC3, 5);
    sys_dn <= 1'b1;
    addr_hi <= 4'h5;
    chk_pins();
    for (int a = 0; a < 6; a++) rd(a);
    @(posedge clk_in);
    internal_exec <= 1'b1;
    chk_pins();
    wr(7, 8'hFF);
    chk_pins();
    rd(7);
    for (int k = 0; k < 8; k++) begin
      wr(0, $random(seed));
      wr_rd(1, $random(seed), 2);
      wr(3, $random(seed));
      wr(5, $random(seed));
      wr(6, k[0] ? 8'h0F : $random(seed));
      ext_h <= 8'($random(seed));
      ext_j <= 8'($random(seed));
      chk_pins();
      for (int a = 0; a < 7; a++) rd(a);
    end
    @(posedge clk_in);
    internal_exec <= 1'b0;
    sys_dn <= 1'b0;
    sys_data <= 8'hE1;
    chk_pins();
    rd(4);
    @(posedge clk_in);
    eight_bit <= 1'b0;
    chk_pins();
    rd(4);
    final_report();
  end
endmodule
